// >>> include/hub_port_power_defines.vh
// constants for the downstream port power and charging control
// assumes a single 125 MHz clock and an active-low asynchronous reset
//
// Function
// [RULE1] individual mode: each port follows its request; code also powers dcp and auto charging ports without a request
// [RULE2] individual mode: overcurrent removes only that port
// [RULE3] ganged mode: any port request powers all
// [RULE4] ganged mode: stay on until all removable
// [RULE5] ganged mode: any overcurrent removes all power
// [RULE6] connected upstream gives cdp, else dcp possible
// [RULE7] automatic charging mode when upstream unconnected
// [RULE8] reset clears registers, block inert while held; code resets the overcurrent synchroniser to all ones instead
// [RULE9] custom strings only from eeprom or slave
// [RULE10] overcurrent inputs are active low
// [RULE11] strap pin latched at reset release; code latches it on the fourth clock edge after release
// [RULE12] overcurrent inputs synchronised before use
`ifndef HUB_PORT_POWER_DEFINES_VH
`define HUB_PORT_POWER_DEFINES_VH

`define NUM_PORTS        4

// charging behaviour per port
`define CHG_OFF          2'h0
`define CHG_CDP          2'h1
`define CHG_DCP          2'h2
`define CHG_AUTO         2'h3

// configuration source
`define CFG_OTP          2'h0
`define CFG_EEPROM       2'h1
`define CFG_SLAVE        2'h2

// cycles after reset release before the strap is taken
`define STRAP_WAIT       2'h3

// reset values
`define RST_POWER        4'h0
`define RST_DRIVE_EN     4'h0
`define RST_OC_FLAG      4'h0
`define RST_OC_PIN       4'hf
`define RST_STRAP        4'h0
`define RST_CHG_MODE     8'h00

`endif

// >>> hdl/sync2.v
// two flip-flop synchroniser for pin levels
// assumes the input is a level, stable for several clocks
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
    parameter                WIDTH   = 4,
    parameter [WIDTH-1:0]    RST_VAL = {WIDTH{1'b0}}
) (
    input  wire              clk,
    input  wire              nrst,
    input  wire [WIDTH-1:0]  d,
    output reg  [WIDTH-1:0]  q
);

    reg [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // sync2

`default_nettype wire

// >>> hdl/hub_port_power_control.v
// downstream port power switching and battery charging selection
// assumes requests, modes and removable flags come from hub logic on clk;
// overcurrent and strap pins are asynchronous and get synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "hub_port_power_defines.vh"

module hub_port_power_control (
    input  wire        clk,
    input  wire        nrst,
    // host port power requests and port states
    input  wire [3:0]  port_power_request,
    input  wire [3:0]  port_removable,
    input  wire        ganged_mode,
    // charging configuration
    input  wire        upstream_connected,
    input  wire        dcp_enable,
    input  wire        charge_auto_mode,
    input  wire [1:0]  config_source,
    // pins
    input  wire [3:0]  port_overcurrent_n,
    input  wire [3:0]  port_power_enable_charge_strap,
    output reg  [3:0]  port_power_drive_q,
    output reg  [3:0]  port_power_drive_en_q,
    // status
    output reg  [3:0]  charge_support_q,
    output reg  [7:0]  charge_mode_q,
    output reg  [3:0]  overcurrent_flag_q,
    output reg         custom_string_enable_q,
    output reg         running_q
);

    localparam [1:0] ST_STRAP = 2'h0;
    localparam [1:0] ST_RUN   = 2'h1;

    // charging behaviour of one port
    function [1:0] charge_select;
        input supported;
        input connected;
        input auto_mode;
        input dcp_on;
        begin
            if (!supported)
                charge_select = `CHG_OFF;
            else if (connected)
                charge_select = `CHG_CDP;
            else if (auto_mode)
                charge_select = `CHG_AUTO;
            else if (dcp_on)
                charge_select = `CHG_DCP;
            else
                charge_select = `CHG_OFF;
        end
    endfunction

    // a dedicated or automatic charger needs vbus without a host request
    function charger_needs_power;
        input [1:0] mode;
        begin
            charger_needs_power = (mode == `CHG_DCP) || (mode == `CHG_AUTO);
        end
    endfunction

    wire [3:0] oc_pin_sync;
    wire [3:0] strap_sync;

    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg  [1:0] wait_cnt_q;
    reg  [1:0] wait_cnt_d;
    reg        gang_on_q;
    reg        gang_on_d;
    reg  [3:0] oc_now;
    reg  [3:0] oc_set;
    reg  [3:0] oc_clr;
    reg  [3:0] want_power;
    reg  [3:0] port_power_drive_d;
    reg  [3:0] port_power_drive_en_d;
    reg  [3:0] charge_support_d;
    reg  [7:0] charge_mode_d;
    reg  [3:0] overcurrent_flag_d;
    reg        custom_string_enable_d;
    reg        running_d;
    integer    i;

    sync2 #(
        .WIDTH   (4),
        .RST_VAL (`RST_OC_PIN)
    ) u_oc_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (port_overcurrent_n),
        .q    (oc_pin_sync)
    ); // RULE12

    sync2 #(
        .WIDTH   (4),
        .RST_VAL (`RST_STRAP)
    ) u_strap_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (port_power_enable_charge_strap),
        .q    (strap_sync)
    );

    always @* begin
        state_d                = state_q;
        wait_cnt_d             = wait_cnt_q;
        gang_on_d              = gang_on_q;
        oc_now                 = 4'h0;
        oc_set                 = 4'h0;
        oc_clr                 = 4'h0;
        want_power             = 4'h0;
        port_power_drive_d     = port_power_drive_q;
        port_power_drive_en_d  = port_power_drive_en_q;
        charge_support_d       = charge_support_q;
        charge_mode_d          = charge_mode_q;
        overcurrent_flag_d     = overcurrent_flag_q;
        custom_string_enable_d = custom_string_enable_q;
        running_d              = running_q;

        case (state_q)
            // pin left undriven so the external strap level can be read
            ST_STRAP: begin
                port_power_drive_d    = `RST_POWER;
                port_power_drive_en_d = 4'h0;
                if (wait_cnt_q == `STRAP_WAIT) begin
                    charge_support_d = strap_sync; // RULE11
                    state_d          = ST_RUN;
                    running_d        = 1'b1;
                end else begin
                    wait_cnt_d = wait_cnt_q + 2'h1;
                end
            end

            ST_RUN: begin
                oc_now = ~oc_pin_sync; // RULE10

                for (i = 0; i < `NUM_PORTS; i = i + 1) begin
                    charge_mode_d[2*i +: 2] = charge_select(
                        charge_support_q[i], upstream_connected,
                        charge_auto_mode, dcp_enable); // RULE6 RULE7
                    want_power[i] = port_power_request[i] |
                        charger_needs_power(charge_mode_q[2*i +: 2]);
                end

                if (ganged_mode)
                    oc_set = {4{|oc_now}}; // RULE5
                else
                    oc_set = oc_now; // RULE2

                // flag drops once host withdraws power and pin is quiet
                oc_clr = ~port_power_request & ~oc_now;
                // a new event beats a clear in the same cycle
                overcurrent_flag_d = oc_set |
                    (overcurrent_flag_q & ~oc_clr);

                if (ganged_mode) begin
                    if (|overcurrent_flag_d)
                        gang_on_d = 1'b0; // RULE5
                    else if (|want_power)
                        gang_on_d = 1'b1; // RULE3
                    else if (&port_removable)
                        gang_on_d = 1'b0; // RULE4
                    port_power_drive_d = {4{gang_on_d}};
                end else begin
                    port_power_drive_d = want_power &
                        ~overcurrent_flag_d; // RULE1 RULE2
                    // a later switch to ganged keeps powered ports on
                    gang_on_d          = |port_power_drive_d; // RULE4
                end

                port_power_drive_en_d  = 4'hf;
                custom_string_enable_d =
                    (config_source == `CFG_EEPROM) ||
                    (config_source == `CFG_SLAVE); // RULE9
            end

            default: begin
                state_d    = ST_STRAP;
                wait_cnt_d = 2'h0;
            end
        endcase
    end

    // everything inert and at defaults while reset is held
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q                <= ST_STRAP; // RULE8
            wait_cnt_q             <= 2'h0;
            gang_on_q              <= 1'b0;
            port_power_drive_q     <= `RST_POWER;
            port_power_drive_en_q  <= `RST_DRIVE_EN;
            charge_support_q       <= `RST_STRAP;
            charge_mode_q          <= `RST_CHG_MODE;
            overcurrent_flag_q     <= `RST_OC_FLAG;
            custom_string_enable_q <= 1'b0;
            running_q              <= 1'b0;
        end else begin
            state_q                <= state_d;
            wait_cnt_q             <= wait_cnt_d;
            gang_on_q              <= gang_on_d;
            port_power_drive_q     <= port_power_drive_d;
            port_power_drive_en_q  <= port_power_drive_en_d;
            charge_support_q       <= charge_support_d;
            charge_mode_q          <= charge_mode_d;
            overcurrent_flag_q     <= overcurrent_flag_d;
            custom_string_enable_q <= custom_string_enable_d;
            running_q              <= running_d;
        end
    end

endmodule // hub_port_power_control

`default_nettype wire

// >>> tb/power_switch_model.sv
// external power switches and strap resistors of the four ports
// assumes the bench commands faults; pins have pull-ups/pull-downs
`timescale 1ns/100ps
`default_nettype none
module power_switch_model (
    input  wire logic [3:0] drive,
    input  wire logic [3:0] drive_en,
    input  wire logic [3:0] fault,
    input  wire logic [3:0] strap,
    output logic      [3:0] oc_n,
    output logic      [3:0] pin
);
    // open drain with pull-up: low only while a fault is flagged
    assign oc_n = ~fault;
    // undriven pin settles to its strap resistor level
    assign pin = (drive_en & drive) | (~drive_en & strap);
endmodule // power_switch_model
`default_nettype wire

// >>> tb/hub_port_power_control_assertions.sv
// port-level checker for the hub port power control
// assumes it is bound to the top module by the bind below
`timescale 1ns/100ps
`default_nettype none
`include "hub_port_power_defines.vh"
module hub_power_checker (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [3:0] port_power_request,
    input wire logic [3:0] port_removable,
    input wire logic       ganged_mode,
    input wire logic       upstream_connected,
    input wire logic [1:0] config_source,
    input wire logic [3:0] port_overcurrent_n,
    input wire logic [3:0] port_power_drive_q,
    input wire logic [3:0] port_power_drive_en_q,
    input wire logic [7:0] charge_mode_q,
    input wire logic [3:0] charge_support_q,
    input wire logic [3:0] overcurrent_flag_q,
    input wire logic       custom_string_enable_q,
    input wire logic       running_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // pins quiet long enough that the synchroniser holds no stale fault
    sequence quiet3;
        (&port_overcurrent_n && running_q)[*3];
    endsequence
    sequence low3(g);
        (ganged_mode == g && running_q && !port_overcurrent_n[2])[*3];
    endsequence
    a_indiv_follow: assert property (quiet3 ##0 (!ganged_mode &&
        overcurrent_flag_q == 4'h0 && (charge_mode_q & 8'haa) == 8'h00)
        |=> port_power_drive_q == $past(port_power_request))
        else $error("individual drive not following request");
    a_oc_isolate: assert property (low3(1'b0) |=>
        overcurrent_flag_q[2] && !port_power_drive_q[2])
        else $error("faulted port still powered");
    a_gang_on: assert property (quiet3 ##0 (ganged_mode &&
        overcurrent_flag_q == 4'h0 && |port_power_request)
        |=> port_power_drive_q == 4'hf) else $error("ganged power not on");
    a_gang_hold: assert property (quiet3 ##0 (ganged_mode &&
        port_power_drive_q == 4'hf && port_removable != 4'hf &&
        overcurrent_flag_q == 4'h0) |=> port_power_drive_q == 4'hf)
        else $error("ganged power dropped early");
    a_gang_oc: assert property (low3(1'b1) |=>
        overcurrent_flag_q == 4'hf && port_power_drive_q == 4'h0)
        else $error("ganged fault left power on");
    a_cdp_conn: assert property (running_q && upstream_connected |=>
        charge_mode_q[1:0] == (charge_support_q[0] ? `CHG_CDP : `CHG_OFF))
        else $error("connected port not in cdp");
    a_custom_str: assert property (running_q |=>
        custom_string_enable_q ==
        ($past(config_source) inside {`CFG_EEPROM, `CFG_SLAVE}))
        else $error("custom string enable wrong");
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst ##1 !nrst |-> !running_q && port_power_drive_q == 4'h0 &&
        port_power_drive_en_q == 4'h0) else $error("active during reset");
    // pin must float until the strap level has been taken
    a_strap_float: assert property (!running_q |->
        port_power_drive_en_q == 4'h0) else $error("pin driven before strap");
    a_pin_driven: assert property (running_q |=>
        port_power_drive_en_q == 4'hf) else $error("pin not driven in run");
    // three wait edges plus the capture edge
    a_strap_wait: assert property ($rose(nrst) |->
        !running_q [*4] ##1 running_q) else $error("strap phase length wrong");
endmodule // hub_power_checker
bind hub_port_power_control hub_power_checker chk (.*);
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the hub port power control
// assumes the switch model and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {int due; logic [20:0] m; logic [20:0] v;} note_t;
    logic        clk = 0, nrst = 0, gang = 0, conn = 1, dcp = 0, autom = 0;
    logic        cs, run;
    logic [1:0]  src = 2'h0, m;
    logic [3:0]  req = 4'h0, rem = 4'h0, fault = 4'h0, strap = 4'h1, r;
    logic [3:0]  drv, en, ocn, pin, flg, sup;
    logic [7:0]  mode;
    logic [20:0] v;
    int          cyc = 0, bad_count = 0, total_checks = 0;
    note_t       notes[$];
    wire  [20:0] snap = {sup, cs, mode, flg, drv};
    hub_port_power_control DUT (.clk(clk), .nrst(nrst),
        .port_power_request(req), .port_removable(rem), .ganged_mode(gang),
        .upstream_connected(conn), .dcp_enable(dcp), .charge_auto_mode(autom),
        .config_source(src), .port_overcurrent_n(ocn),
        .port_power_enable_charge_strap(pin), .port_power_drive_q(drv),
        .port_power_drive_en_q(en), .charge_support_q(sup),
        .charge_mode_q(mode), .overcurrent_flag_q(flg),
        .custom_string_enable_q(cs), .running_q(run));
    power_switch_model sw (.drive(drv), .drive_en(en), .fault(fault),
        .strap(strap), .oc_n(ocn), .pin(pin));
    always #4 clk = ~clk;
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // lat counts edges after the edge that changed the inputs
    task automatic note(int lat, logic [20:0] mk, logic [20:0] val);
        notes.push_back('{cyc + 1 + lat, mk, val});
    endtask
    task automatic check(logic [20:0] seen, logic [20:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        // a note never compared is a missed result
        if (notes.size() > 0)
            bad_count++;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        while (notes.size() > 0 && notes[0].due == cyc) begin
            check(snap & notes[0].m, notes[0].v);
            void'(notes.pop_front());
        end
    end
    initial begin
        void'($urandom(71135));
        strap = 4'h1 | 4'($urandom);
        tick(6);
        nrst <= 1'b1;
        tick(6);
        note(0, 21'h1e_0000, {strap, 17'h0_0000});
        for (int i = 0; i < 6; i++) begin
            tick(1);
            r = 4'($urandom);
            req <= r;
            note(1, 21'h00_000f, 21'(r));
        end
        tick(1);
        req <= 4'hf;
        fault <= 4'h4;
        note(3, 21'h00_00ff, 21'h00_004b);
        tick(4);
        fault <= 4'h0;
        req <= 4'hb;
        tick(4);
        req <= 4'hf;
        note(1, 21'h00_00ff, 21'h00_000f);
        tick(1);
        req <= 4'h0;
        rem <= 4'hf;
        note(1, 21'h00_000f, 21'h00_0000);
        tick(1);
        gang <= 1'b1;
        req <= 4'h2;
        rem <= 4'h0;
        note(1, 21'h00_000f, 21'h00_000f);
        tick(1);
        req <= 4'h0;
        rem <= 4'h7;
        tick(3);
        note(0, 21'h00_000f, 21'h00_000f);
        rem <= 4'hf;
        note(1, 21'h00_000f, 21'h00_0000);
        tick(2);
        req <= 4'h8;
        note(1, 21'h00_000f, 21'h00_000f);
        tick(2);
        fault <= 4'h4;
        note(3, 21'h00_00ff, 21'h00_00f0);
        tick(4);
        fault <= 4'h0;
        req <= 4'h0;
        gang <= 1'b0;
        tick(5);
        note(0, 21'h00_00ff, 21'h00_0000);
        // every charging input combination, one per cycle
        for (int i = 0; i < 8; i++) begin
            tick(1);
            {conn, autom, dcp} <= i[2:0];
            m = i[2] ? 2'h1 : i[1] ? 2'h3 : i[0] ? 2'h2 : 2'h0;
            v = 21'h00_0000;
            for (int p = 0; p < 4; p++)
                v[8 + 2 * p +: 2] = strap[p] ? m : 2'h0;
            note(1, 21'h00_ff00, v);
        end
        for (int i = 0; i < 4; i++) begin
            tick(1);
            src <= i[1:0];
            note(1, 21'h01_0000, {i == 1 || i == 2, 16'h0000});
        end
        // spare cycle so the last source check is not masked by reset
        tick(2);
        nrst <= 1'b0;
        // new strap while held: the second capture must see it
        strap <= strap ^ 4'he;
        note(0, 21'h1f_ffff, 21'h00_0000);
        tick(2);
        nrst <= 1'b1;
        tick(8);
        note(0, 21'h1e_0000, {strap, 17'h0_0000});
        tick(3);
        stop_test();
    end
    initial begin
        repeat (1500) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule // testbench
`default_nettype wire
